//--- qpd_unit.v
// one decoder channel: edge decode, count, divider, idle timer, clear
// assumes phase and clear inputs already synchronous
`timescale 1ns/1ps
`default_nettype none
`include "qpd_defines.vh"

module qpd_unit (
    input wire clock_i, // device clock
    input wire arst_n_i, // async reset, low active
    input wire phase_a_i, // selected phase a
    input wire phase_b_i, // selected phase b
    input wire clear_src_i, // selected clear source level
    input wire count_mode_select_i, // 0 four-edge filtered, 1 fine
    input wire [`QPD_DIV_W-1:0] pulse_divide_count_i, // steps per pulse
    input wire [1:0] pulse_condition_select_i, // pulse condition
    input wire [`QPD_TMO_W-1:0] idle_timeout_i, // idle time in us
    input wire [2:0] clear_activation_select_i, // clear activation
    input wire soft_clear_i, // software clear pulse
    input wire write_i, // overwrite count pulse
    input wire [`QPD_CNT_W-1:0] write_data_i, // new count
    output reg [`QPD_CNT_W-1:0] position_count_o, // live count
    output reg [`QPD_CNT_W-1:0] snapshot_o, // count at last clear
    output reg moving_o, // motion state
    output reg pulse_o // divided output pulse
);
    // ****************************************
    // phase history and clear edge detect
    // ****************************************
    reg a_q; // previous phase a
    reg b_q; // previous phase b
    reg clr_q; // previous clear level
    reg last_dir; // last step direction, 1 = up
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            clr_q <= 1'b0;
        end else begin
            a_q <= phase_a_i;
            b_q <= phase_b_i;
            clr_q <= clear_src_i;
        end
    end

    // ****************************************
    // step decode
    // ****************************************
    wire a_chg = phase_a_i ^ a_q; // a toggled
    wire b_chg = phase_b_i ^ b_q; // b toggled
    // a leading b: up when new a differs from old b
    wire dir_up = phase_a_i ^ b_q;
    wire one_chg = a_chg ^ b_chg; // a valid single step
    // filtered mode: a step reversing the last direction on the same phase is jitter
    // and is absorbed; fine mode counts every single-phase edge
    reg step_en; // count this edge
    always @* begin
        step_en = one_chg;
        if (count_mode_select_i == `QPD_MODE_FOUR_EDGE && one_chg && dir_up != last_dir) begin
            step_en = 1'b0;
        end
    end
    // a reversal in filtered mode still records the new direction, so real
    // reversals cost one edge; trade of a count for noise immunity
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            last_dir <= 1'b1;
        end else if (one_chg) begin
            last_dir <= dir_up;
        end
    end

    // ****************************************
    // hardware clear activation
    // ****************************************
    reg hw_clear; // hardware clear hit
    always @* begin
        case (clear_activation_select_i)
            `QPD_ACT_RISE: hw_clear = clear_src_i & ~clr_q;
            `QPD_ACT_FALL: hw_clear = ~clear_src_i & clr_q;
            `QPD_ACT_ANY: hw_clear = clear_src_i ^ clr_q;
            `QPD_ACT_HIGH: hw_clear = clear_src_i;
            `QPD_ACT_LOW: hw_clear = ~clear_src_i;
            default: hw_clear = 1'b0;
        endcase
    end
    wire any_clear = hw_clear | soft_clear_i;
    reg clear_q; // clear active at last edge
    // a held level clear must not overwrite the snapshot with zero every cycle,
    // so only the first cycle of a clear run captures the count
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clear_q <= 1'b0;
        end else begin
            clear_q <= any_clear;
        end
    end

    // ****************************************
    // position counter and snapshot
    // ****************************************
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            position_count_o <= {`QPD_CNT_W{1'b0}};
            snapshot_o <= {`QPD_CNT_W{1'b0}};
        end else if (any_clear) begin
            if (!clear_q) begin
                snapshot_o <= position_count_o;
            end
            position_count_o <= {`QPD_CNT_W{1'b0}};
        end else if (write_i) begin
            position_count_o <= write_data_i;
        end else if (step_en) begin
            if (dir_up) begin
                position_count_o <= position_count_o + 1'b1;
            end else begin
                position_count_o <= position_count_o - 1'b1;
            end
        end
    end

    // ****************************************
    // divider for the output pulse
    // ****************************************
    reg [`QPD_DIV_W-1:0] div_cnt; // steps since last pulse
    reg pulse_ok; // condition met for this step
    always @* begin
        case (pulse_condition_select_i)
            `QPD_PULSE_ANY: pulse_ok = 1'b1;
            `QPD_PULSE_FWD: pulse_ok = dir_up;
            `QPD_PULSE_REV: pulse_ok = ~dir_up;
            default: pulse_ok = 1'b0;
        endcase
    end
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_cnt <= {`QPD_DIV_W{1'b0}};
            pulse_o <= 1'b0;
        end else begin
            pulse_o <= 1'b0;
            if (any_clear) begin
                div_cnt <= {`QPD_DIV_W{1'b0}};
            end else if (step_en && pulse_ok) begin
                // divide count of 0 or 1 both give one pulse per step
                if (div_cnt + 1'b1 >= pulse_divide_count_i) begin
                    div_cnt <= {`QPD_DIV_W{1'b0}};
                    pulse_o <= 1'b1;
                end else begin
                    div_cnt <= div_cnt + 1'b1;
                end
            end
        end
    end

    // ****************************************
    // idle timeout in microseconds
    // ****************************************
    reg [`QPD_TICK_W-1:0] us_tick; // cycles within one us
    reg [`QPD_TMO_W-1:0] idle_us; // whole us without a step
    wire us_end = (us_tick == `QPD_TICKS_PER_US - 1); // one us elapsed
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            us_tick <= {`QPD_TICK_W{1'b0}};
            idle_us <= {`QPD_TMO_W{1'b0}};
            moving_o <= 1'b0;
        end else if (step_en) begin
            us_tick <= {`QPD_TICK_W{1'b0}};
            idle_us <= {`QPD_TMO_W{1'b0}};
            moving_o <= 1'b1;
        end else if (us_end) begin
            us_tick <= {`QPD_TICK_W{1'b0}};
            if (idle_us + 1'b1 >= idle_timeout_i) begin
                moving_o <= 1'b0;
            end else begin
                idle_us <= idle_us + 1'b1;
            end
        end else begin
            us_tick <= us_tick + 1'b1;
        end
    end
endmodule // qpd_unit

`default_nettype wire

//--- qpd_defines.vh
// constants for the quadrature position decoder
// assumes a single 40 mhz clock and plain-port configuration
`ifndef QPD_DEFINES_VH
`define QPD_DEFINES_VH

// ****************************************
// sizes
// ****************************************
`define QPD_UNITS 4
`define QPD_UNIT_W 2
`define QPD_SRC_N 8
`define QPD_SRC_W 3
`define QPD_CNT_W 32
`define QPD_DIV_W 16
`define QPD_TMO_W 20

// ****************************************
// timing
// ****************************************
`define QPD_CLK_MHZ 40
`define QPD_TICKS_PER_US `QPD_CLK_MHZ
`define QPD_TICK_W 6

// ****************************************
// encodings
// ****************************************
`define QPD_MODE_FOUR_EDGE 1'b0
`define QPD_MODE_FINE 1'b1
`define QPD_PULSE_ANY 2'h0
`define QPD_PULSE_FWD 2'h1
`define QPD_PULSE_REV 2'h2
`define QPD_PULSE_OFF 2'h3
`define QPD_ACT_RISE 3'h0
`define QPD_ACT_FALL 3'h1
`define QPD_ACT_ANY 3'h2
`define QPD_ACT_HIGH 3'h3
`define QPD_ACT_LOW 3'h4
`define QPD_SRC_NONE 3'h7

`endif

//--- qpd_sync.v
// two-flop synchroniser vector for pin inputs
// assumes inputs are asynchronous to clock_i
`timescale 1ns/1ps
`default_nettype none

module qpd_sync #(
    parameter W = 8
) (
    input wire clock_i, // device clock
    input wire arst_n_i, // async reset, low active
    input wire [W-1:0] async_i, // raw pins
    output wire [W-1:0] sync_o // synchronised copy
);
    // ****************************************
    // two stages, first stage read only by second
    // ****************************************
    reg [W-1:0] stage_a; // metastable catch
    reg [W-1:0] stage_b; // settled value
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage_a <= {W{1'b0}};
            stage_b <= {W{1'b0}};
        end else begin
            stage_a <= async_i;
            stage_b <= stage_a;
        end
    end
    assign sync_o = stage_b;
endmodule // qpd_sync

`default_nettype wire

//--- qpd_top.v
// quadrature position decoder, several units behind a unit selector
// assumes pins are asynchronous; config ports are on clock_i
`timescale 1ns/1ps
`default_nettype none
`include "qpd_defines.vh"

module qpd_top (
    input wire clock_i, // device clock 40 mhz
    input wire arst_n_i, // async reset, low active
    input wire [`QPD_SRC_N-1:0] source_pins_i, // raw candidate signals
    input wire [`QPD_UNIT_W-1:0] unit_select_i, // unit for config access
    input wire cfg_write_i, // write pulse for setting ports
    input wire [`QPD_SRC_W-1:0] phase_a_source_select_i, // phase a source
    input wire [`QPD_SRC_W-1:0] phase_b_source_select_i, // phase b source
    input wire count_mode_select_i, // counting mode
    input wire [`QPD_DIV_W-1:0] pulse_divide_count_i, // divide count
    input wire [1:0] pulse_condition_select_i, // pulse condition
    input wire [`QPD_TMO_W-1:0] idle_timeout_i, // timeout in us
    input wire [`QPD_SRC_W-1:0] clear_source_select_i, // clear source
    input wire [2:0] clear_activation_select_i, // clear activation
    input wire soft_counter_clear_i, // soft clear pulse for selected unit
    input wire position_write_i, // overwrite count of selected unit
    input wire [`QPD_CNT_W-1:0] position_write_data_i, // new count value
    output reg [`QPD_CNT_W-1:0] position_count_o, // selected unit count
    output reg [`QPD_CNT_W-1:0] position_snapshot_on_clear_o, // selected snapshot
    output reg motion_state_o, // selected unit moving
    output wire [`QPD_UNITS-1:0] pulse_o // divided pulses, one per unit
);
    // ****************************************
    // pin synchronisation
    // ****************************************
    wire [`QPD_SRC_N-1:0] src_sync; // pins after two flops
    qpd_sync #(.W(`QPD_SRC_N)) u_sync (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .async_i(source_pins_i),
        .sync_o(src_sync)
    );

    // ****************************************
    // per-unit settings and decoder channels
    // ****************************************
    wire [`QPD_CNT_W-1:0] cnt_w [0:`QPD_UNITS-1]; // unit counts
    wire [`QPD_CNT_W-1:0] snap_w [0:`QPD_UNITS-1]; // unit snapshots
    wire [`QPD_UNITS-1:0] mov_w; // unit motion states

    genvar g;
    generate
        for (g = 0; g < `QPD_UNITS; g = g + 1) begin : g_unit
            reg [`QPD_SRC_W-1:0] src_a; // phase a source
            reg [`QPD_SRC_W-1:0] src_b; // phase b source
            reg [`QPD_SRC_W-1:0] src_c; // clear source
            reg mode; // count mode
            reg [`QPD_DIV_W-1:0] div; // divide count
            reg [1:0] pcond; // pulse condition
            reg [`QPD_TMO_W-1:0] tmo; // idle timeout
            reg [2:0] act; // clear activation
            wire hit = (unit_select_i == g); // this unit addressed
            // settings are latched only into the addressed unit
            always @(posedge clock_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    src_a <= 3'h0;
                    src_b <= 3'h1;
                    src_c <= `QPD_SRC_NONE;
                    mode <= `QPD_MODE_FOUR_EDGE;
                    div <= 16'h0001;
                    pcond <= `QPD_PULSE_ANY;
                    tmo <= 20'h003e8;
                    act <= `QPD_ACT_RISE;
                end else if (cfg_write_i && hit) begin
                    src_a <= phase_a_source_select_i;
                    src_b <= phase_b_source_select_i;
                    src_c <= clear_source_select_i;
                    mode <= count_mode_select_i;
                    div <= pulse_divide_count_i;
                    pcond <= pulse_condition_select_i;
                    tmo <= idle_timeout_i;
                    act <= clear_activation_select_i;
                end
            end
            // source none holds the clear input low; the top source index
            // is therefore not usable as a clear source
            wire clr_lvl = (src_c == `QPD_SRC_NONE) ? 1'b0 : src_sync[src_c];
            qpd_unit u_unit (
                .clock_i(clock_i),
                .arst_n_i(arst_n_i),
                .phase_a_i(src_sync[src_a]),
                .phase_b_i(src_sync[src_b]),
                .clear_src_i(clr_lvl),
                .count_mode_select_i(mode),
                .pulse_divide_count_i(div),
                .pulse_condition_select_i(pcond),
                .idle_timeout_i(tmo),
                .clear_activation_select_i(act),
                .soft_clear_i(soft_counter_clear_i & hit),
                .write_i(position_write_i & hit),
                .write_data_i(position_write_data_i),
                .position_count_o(cnt_w[g]),
                .snapshot_o(snap_w[g]),
                .moving_o(mov_w[g]),
                .pulse_o(pulse_o[g])
            );
        end
    endgenerate

    // ****************************************
    // read-back of the selected unit, registered
    // ****************************************
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            position_count_o <= {`QPD_CNT_W{1'b0}};
            position_snapshot_on_clear_o <= {`QPD_CNT_W{1'b0}};
            motion_state_o <= 1'b0;
        end else begin
            position_count_o <= cnt_w[unit_select_i];
            position_snapshot_on_clear_o <= snap_w[unit_select_i];
            motion_state_o <= mov_w[unit_select_i];
        end
    end
endmodule // qpd_top

`default_nettype wire

//--- qpd_top_properties.sv
// port-level checker for the quadrature position decoder
// assumes it is bound onto qpd_top with all ports visible
`timescale 1ns/1ps
`default_nettype none
`include "qpd_defines.vh"
module qpd_top_properties (
    input wire clock_i, // device clock
    input wire arst_n_i, // async reset, low active
    input wire [`QPD_SRC_N-1:0] source_pins_i, // candidate pins
    input wire [`QPD_UNIT_W-1:0] unit_select_i, // unit select
    input wire cfg_write_i, // setting strobe
    input wire soft_counter_clear_i, // soft clear strobe
    input wire position_write_i, // count write strobe
    input wire [`QPD_CNT_W-1:0] position_write_data_i, // write data
    input wire [`QPD_CNT_W-1:0] position_count_o, // count readback
    input wire [`QPD_CNT_W-1:0] position_snapshot_on_clear_o, // snapshot
    input wire motion_state_o, // moving flag
    input wire [`QPD_UNITS-1:0] pulse_o // divided pulses
);
    // ****************************************
    // quiet timer: edges since anything could move an output
    // ****************************************
    reg [2:0] quiet; // saturates at 7
    reg [`QPD_SRC_N-1:0] pins_q; // pins at last edge
    reg [`QPD_UNIT_W-1:0] sel_q; // select at last edge
    wire cause = (source_pins_i != pins_q) | (unit_select_i != sel_q) | cfg_write_i
        | soft_counter_clear_i | position_write_i; // any stimulus
    // pin path is sync, decode and readback, so 7 quiet edges is ample
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            quiet <= 3'h7;
            pins_q <= {`QPD_SRC_N{1'b0}};
            sel_q <= {`QPD_UNIT_W{1'b0}};
        end else begin
            quiet <= cause ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
            pins_q <= source_pins_i;
            sel_q <= unit_select_i;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    // strobe taken with no step in flight and select held afterwards
    sequence s_calm(x);
        x && quiet > 3'h3 ##1 unit_select_i == sel_q;
    endsequence
    chk_reset_clean: assert property ($rose(arst_n_i) |-> position_count_o == 0
        && position_snapshot_on_clear_o == 0 && !motion_state_o && pulse_o == 0)
        else $error("outputs not clear after reset");
    chk_write_load: assert property (s_calm(position_write_i && !soft_counter_clear_i) |=>
        position_count_o == $past(position_write_data_i, 2) || position_count_o == 0)
        else $error("written count not read back");
    chk_soft_zero: assert property (s_calm(soft_counter_clear_i) |=> position_count_o == 0)
        else $error("soft clear left count nonzero");
    chk_snap_capture: assert property (s_calm(soft_counter_clear_i) |=>
        position_snapshot_on_clear_o == $past(position_count_o, 2))
        else $error("snapshot missed count at clear");
    chk_count_cause: assert property ($changed(position_count_o) |-> quiet != 3'h7)
        else $error("count moved with no cause");
    chk_snap_cause: assert property ($changed(position_snapshot_on_clear_o) |-> quiet != 3'h7)
        else $error("snapshot moved with no clear");
    chk_pulse_cause: assert property (|pulse_o |-> quiet != 3'h7)
        else $error("pulse with no step");
    chk_motion_cause: assert property ($rose(motion_state_o) |-> quiet != 3'h7)
        else $error("moving without a step");
    cover property (|pulse_o);
    cover property ($fell(motion_state_o));
    cover property (s_calm(soft_counter_clear_i));
endmodule // qpd_top_properties
bind qpd_top qpd_top_properties chk (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .source_pins_i(source_pins_i), .unit_select_i(unit_select_i), .cfg_write_i(cfg_write_i),
    .soft_counter_clear_i(soft_counter_clear_i), .position_write_i(position_write_i),
    .position_write_data_i(position_write_data_i), .position_count_o(position_count_o),
    .position_snapshot_on_clear_o(position_snapshot_on_clear_o),
    .motion_state_o(motion_state_o), .pulse_o(pulse_o));
`default_nettype wire

//--- qpd_enc_model.sv
// incremental encoder stand-in: two phases in quadrature
// assumes step_i is a one-cycle strobe from the bench
`timescale 1ns/1ps
`default_nettype none
module qpd_enc_model (
    input wire logic clock_i, // bench clock
    input wire logic step_i, // one step per strobe
    input wire logic up_i, // 1 makes a lead b
    output logic phase_a_o, // phase a
    output logic phase_b_o // phase b
);
    logic [1:0] pos = 2'h0; // shaft position mod four
    // one phase moves per step, never both, so no step is ambiguous
    always @(posedge clock_i) begin
        if (step_i) begin
            pos <= up_i ? pos + 2'h1 : pos - 2'h1;
        end
    end
    // gray order 00 10 11 01 as (a,b) going up
    assign phase_a_o = pos[1] ^ pos[0];
    assign phase_b_o = pos[1];
endmodule // qpd_enc_model
`default_nettype wire

//--- tb_top.sv
// self-checking bench for qpd_top
// assumes encoder model on pins 0 and 1, clear line on pin 2
`timescale 1ns/1ps
`default_nettype none
`include "qpd_defines.vh"
module tb_top;
    logic clock_i = 1'b0; // 40 mhz
    logic arst_n_i = 1'b0; // reset, low active
    logic clr = 1'b0, step = 1'b0, up = 1'b1; // clear pin, encoder strobe, direction
    wire ea, eb; // encoder phases
    logic [1:0] sel = 2'h0, cond = 2'h0; // unit, pulse condition
    logic [2:0] sa = 3'h0, sb = 3'h1, cs = 3'h7, act = 3'h0; // sources, activation
    logic cw = 1'b0, md = 1'b0, sc = 1'b0, pw = 1'b0; // strobes and mode
    logic [15:0] div = 16'h0001; // divide count
    logic [19:0] tmo = 20'h003e8; // idle timeout in us
    logic [31:0] wd = 32'h0; // write data
    wire [31:0] cnt, snap; // readback
    wire mov; // motion state
    wire [3:0] pls; // pulses
    int error_cnt = 0, check_count = 0, cyc = 0; // tallies
    int pc [4] = '{0, 0, 0, 0}; // pulses seen per unit
    int re [5] = '{0, 7, 0, 0, 0}; // count after clear line rises, per activation
    int fe [5] = '{7, 0, 0, 0, 0}; // count after clear line falls
    int rs [5] = '{7, 7, 7, 7, 0}; // snapshot after clear line rises; after fall it is always 7
    qpd_enc_model enc (.clock_i(clock_i), .step_i(step), .up_i(up), .phase_a_o(ea), .phase_b_o(eb));
    qpd_top DUT (.clock_i(clock_i), .arst_n_i(arst_n_i), .source_pins_i({5'h00, clr, eb, ea}),
        .unit_select_i(sel), .cfg_write_i(cw), .phase_a_source_select_i(sa),
        .phase_b_source_select_i(sb), .count_mode_select_i(md), .pulse_divide_count_i(div),
        .pulse_condition_select_i(cond), .idle_timeout_i(tmo), .clear_source_select_i(cs),
        .clear_activation_select_i(act), .soft_counter_clear_i(sc), .position_write_i(pw),
        .position_write_data_i(wd), .position_count_o(cnt), .position_snapshot_on_clear_o(snap),
        .motion_state_o(mov), .pulse_o(pls));
    initial forever #12.5 clock_i = ~clock_i;
    // ****************************************
    // pulse tally and hang guard
    // ****************************************
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        for (int u = 0; u < 4; u++) pc[u] <= pc[u] + pls[u];
        // run needs about 700 cycles; well past that means a hang
        if (cyc == 8000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // one-cycle strobe on the selected unit; select settles five edges ahead
    // so the strobe meets a calm readback and the checker's strobe checks engage
    task automatic strobe(input logic [1:0] u, input logic c, s, w, input logic [31:0] d);
        @(posedge clock_i);
        sel <= u;
        tick(5);
        {cw, sc, pw, wd} <= {c, s, w, d};
        @(posedge clock_i);
        {cw, sc, pw} <= 3'h0;
    endtask
    task automatic cfg(input logic [1:0] u, input logic [2:0] a, b, input logic m,
        input logic [15:0] d, input logic [1:0] c, input logic [19:0] t, input logic [2:0] s, x);
        @(posedge clock_i);
        {sa, sb, md, div, cond, tmo, cs, act} <= {a, b, m, d, c, t, s, x};
        strobe(u, 1'b1, 1'b0, 1'b0, 32'h0);
    endtask
    // readback lags the select by one edge; sample clear of the edge
    task automatic rd(input logic [1:0] u, input logic [31:0] ec, es);
        @(posedge clock_i);
        sel <= u;
        tick(3);
        #1;
        check(cnt, ec);
        check(snap, es);
    endtask
    task automatic move(input logic d, input int n);
        repeat (n) begin
            @(posedge clock_i);
            {up, step} <= {d, 1'b1};
            @(posedge clock_i);
            step <= 1'b0;
            tick(6);
        end
        tick(6);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        tick(16);
        arst_n_i <= 1'b1;
        tick(2);
        for (int u = 0; u < 4; u++) rd(u[1:0], 32'h0, 32'h0);
        check({31'h0, mov}, 32'h0);
        for (int u = 0; u < 4; u++) strobe(u[1:0], 1'b0, 1'b0, 1'b1, 32'h100 + u);
        for (int u = 0; u < 4; u++) rd(u[1:0], 32'h100 + u, 32'h0);
        $display("test select and write done");
        // four units see the same encoder with different settings
        cfg(2'h0, 3'h0, 3'h1, 1'b1, 16'h4, 2'h0, 20'h2, 3'h7, 3'h0);
        cfg(2'h1, 3'h0, 3'h1, 1'b0, 16'h1, 2'h1, 20'h3e8, 3'h7, 3'h0);
        cfg(2'h2, 3'h0, 3'h1, 1'b1, 16'h1, 2'h3, 20'h3e8, 3'h7, 3'h0);
        cfg(2'h3, 3'h1, 3'h0, 1'b1, 16'h2, 2'h2, 20'h3e8, 3'h7, 3'h0);
        move(1'b1, 8);
        rd(2'h0, 32'h108, 32'h0);
        move(1'b0, 8);
        rd(2'h0, 32'h100, 32'h0);
        check({31'h0, mov}, 32'h1);
        rd(2'h1, 32'h102, 32'h0);
        rd(2'h2, 32'h102, 32'h0);
        rd(2'h3, 32'h103, 32'h0);
        check(pc[0], 4);
        check(pc[1], 8);
        check(pc[2], 0);
        check(pc[3], 4);
        check({31'h0, mov}, 32'h1);
        rd(2'h0, 32'h100, 32'h0);
        tick(200);
        check({31'h0, mov}, 32'h0);
        $display("test counting and pulses done");
        strobe(2'h0, 1'b0, 1'b0, 1'b1, 32'h5);
        strobe(2'h0, 1'b0, 1'b1, 1'b1, 32'h9);
        rd(2'h0, 32'h0, 32'h5);
        move(1'b1, 2);
        rd(2'h0, 32'h2, 32'h5);
        $display("test soft clear done");
        for (int k = 0; k < 5; k++) begin
            cfg(2'h2, 3'h0, 3'h1, 1'b1, 16'h1, 2'h3, 20'h3e8, 3'h2, k[2:0]);
            strobe(2'h2, 1'b0, 1'b0, 1'b1, 32'h7);
            clr <= 1'b1;
            tick(4);
            rd(2'h2, re[k], rs[k]);
            if (k == 0) check(snap, 32'h7);
            strobe(2'h2, 1'b0, 1'b0, 1'b1, 32'h7);
            clr <= 1'b0;
            tick(4);
            rd(2'h2, fe[k], 32'h7);
        end
        $display("test hardware clear done");
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
